/* hw/cirq_pkg.sv */
// package: constants for the charger interrupt mask and status register slice
//
// Behaviour
// - mask register at 0x01, device 0x6A, resets 0x00
// - mask bit 1 masks source, bit 0 unused
// - summary 7/6 copy invalid and limited details
// - summary 5 follows overvoltage detail
// - summary 4 high when undervoltage invalidates input
// - summary 3 high for charger codes 5..8
// - summary 2 high for battery codes 01, 11
// - summary 1 low only for zones 100, 101
// - detail 7 input invalid, 3 reserved, 2:0 zone
// - detail 6 high while input current limited
// - detail 4 undervolt valid, detail 5 overvolt
// - zone codes cold, cool, normal, warm, hot
// - charger codes done, fault, temp, off
// - battery codes low, fault, ok, overvoltage
package cirq_pkg;

    // ==========================================
    // bus address and register offsets
    localparam logic [6:0] DEV_ADDR = 7'h6a;
    localparam logic [7:0] OFS_MASK = 8'h01;
    localparam logic [7:0] OFS_SUMMARY = 8'h02;
    localparam logic [7:0] OFS_DETAIL = 8'h03;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ==========================================
    // reset values
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] DETAIL_RST = 8'h00;
    localparam logic [3:0] CHG_CODE_RST = 4'h0;
    localparam logic [1:0] BAT_CODE_RST = 2'h0;
    localparam logic [7:0] MASK_WR_BITS = 8'hfe;

    // ==========================================
    // bit positions, shared by mask, summary and detail
    localparam int BIT_INPUT_LIMIT = 7;
    localparam int BIT_TOPOFF = 6;
    localparam int BIT_OVERVOLT = 5;
    localparam int BIT_UNDERVOLT = 4;
    localparam int BIT_CHARGER = 3;
    localparam int BIT_BATTERY = 2;
    localparam int BIT_THERMISTOR = 1;
    localparam int BIT_INPUT_INVALID = 7;
    localparam int BIT_CURRENT_LIMITED = 6;
    localparam int BIT_RESERVED = 3;
    localparam int THM_LSB = 0;
    localparam int THM_W = 3;

    // ==========================================
    // thermistor zone codes
    localparam logic [2:0] THM_COLD = 3'h1;
    localparam logic [2:0] THM_COOL = 3'h2;
    localparam logic [2:0] THM_NORMAL = 3'h3;
    localparam logic [2:0] THM_WARM = 3'h4;
    localparam logic [2:0] THM_HOT = 3'h5;

    // ==========================================
    // charger state codes that mean suspended
    localparam logic [3:0] CHG_DONE = 4'h5;
    localparam logic [3:0] CHG_TIMER_FAULT = 4'h6;
    localparam logic [3:0] CHG_TEMP_SUSPEND = 4'h7;
    localparam logic [3:0] CHG_OFF = 4'h8;

    // ==========================================
    // battery state codes
    localparam logic [1:0] BAT_LOW = 2'h0;
    localparam logic [1:0] BAT_TIMER_FAULT = 2'h1;
    localparam logic [1:0] BAT_GOOD = 2'h2;
    localparam logic [1:0] BAT_OVERVOLT = 2'h3;

    // ==========================================
    // pin synchroniser width and bit counting
    localparam int SYNC_W = 16;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage : cirq_pkg

/* hw/cirq_sync3.sv */
// module: three-stage pin synchroniser, output moves once stages two and three agree
`timescale 1ns/100ps
module cirq_sync3 (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // data
    input wire logic d_i,
    output logic q_o
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    // ==========================================
    // chain and agreement filter
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            q_o <= 1'b0;
        end
        else
        begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
            begin
                q_o <= s3_q;
            end
        end
    end

endmodule : cirq_sync3

/* hw/cirq_regs.sv */
// module: i2c reachable mask, summary status and detail registers of the charger
`timescale 1ns/100ps
module cirq_regs (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // i2c pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // analog status
    input wire logic safe_output_power_good_i,
    input wire logic input_voltage_invalid_i,
    input wire logic input_current_limited_i,
    input wire logic input_overvolt_detail_i,
    input wire logic input_undervolt_detail_i,
    input wire logic [2:0] thermistor_zone_code_i,
    input wire logic [3:0] charger_state_code_i,
    input wire logic [1:0] battery_state_code_i,
    // interrupt
    input wire logic [6:0] irq_pending_i,
    output logic charger_irq_o
);

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
    } cirq_state_t;

    logic [cirq_pkg::SYNC_W-1:0] raw;
    logic [cirq_pkg::SYNC_W-1:0] syn;
    logic scl_f;
    logic sda_f;
    logic pg_f;
    logic scl_p_q;
    logic sda_p_q;
    logic pg_p_q;
    logic pg_rise;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    cirq_state_t st_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [7:0] ptr_q;
    logic nack_q;
    logic wr_en;
    logic [7:0] mask_q;
    logic [7:0] detail_q;
    logic [3:0] chg_code_q;
    logic [1:0] bat_code_q;
    logic [7:0] summary;
    logic chg_susp;
    logic bat_bad;
    logic thm_out;
    logic [7:0] rd_byte;

    // ==========================================
    // pin synchronisers
    assign raw = {scl_i, sda_i, safe_output_power_good_i, input_voltage_invalid_i,
        input_current_limited_i, input_overvolt_detail_i, input_undervolt_detail_i,
        thermistor_zone_code_i, charger_state_code_i, battery_state_code_i};

    for (genvar g = 0; g < cirq_pkg::SYNC_W; g++)
    begin : g_sync
        cirq_sync3 u_sync (
            .clk_sys_i(clk_sys_i),
            .nrst_i(nrst_i),
            .d_i(raw[g]),
            .q_o(syn[g])
        );
    end

    assign scl_f = syn[15];
    assign sda_f = syn[14];
    assign pg_f = syn[13];

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            // match the synchroniser reset level, so no false edge follows reset
            scl_p_q <= 1'b0;
            sda_p_q <= 1'b0;
            pg_p_q <= 1'b0;
        end
        else
        begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
            pg_p_q <= pg_f;
        end
    end

    assign pg_rise = pg_f & ~pg_p_q;
    assign scl_rise = scl_f & ~scl_p_q;
    assign scl_fall = ~scl_f & scl_p_q;
    assign start_c = scl_f & scl_p_q & sda_p_q & ~sda_f;
    assign stop_c = scl_f & scl_p_q & ~sda_p_q & sda_f;

    // ==========================================
    // summary status, derived from detail and the charger and battery state codes
    always_comb
    begin
        chg_susp = (chg_code_q == cirq_pkg::CHG_DONE) ||
            (chg_code_q == cirq_pkg::CHG_TIMER_FAULT) ||
            (chg_code_q == cirq_pkg::CHG_TEMP_SUSPEND) || (chg_code_q == cirq_pkg::CHG_OFF);
        bat_bad = (bat_code_q == cirq_pkg::BAT_TIMER_FAULT) ||
            (bat_code_q == cirq_pkg::BAT_OVERVOLT);
        thm_out = !((detail_q[2:0] == cirq_pkg::THM_WARM) ||
            (detail_q[2:0] == cirq_pkg::THM_HOT));
        summary = 8'h00;
        summary[cirq_pkg::BIT_INPUT_LIMIT] = detail_q[cirq_pkg::BIT_INPUT_INVALID];
        summary[cirq_pkg::BIT_TOPOFF] = detail_q[cirq_pkg::BIT_CURRENT_LIMITED];
        summary[cirq_pkg::BIT_OVERVOLT] = detail_q[cirq_pkg::BIT_OVERVOLT];
        summary[cirq_pkg::BIT_UNDERVOLT] = ~detail_q[cirq_pkg::BIT_UNDERVOLT];
        summary[cirq_pkg::BIT_CHARGER] = chg_susp;
        summary[cirq_pkg::BIT_BATTERY] = bat_bad;
        summary[cirq_pkg::BIT_THERMISTOR] = thm_out;
    end

    function automatic logic [7:0] read_reg(input logic [7:0] ofs, input logic [7:0] m,
        input logic [7:0] s, input logic [7:0] d);
        case (ofs)
            cirq_pkg::OFS_MASK: read_reg = m;
            cirq_pkg::OFS_SUMMARY: read_reg = s;
            cirq_pkg::OFS_DETAIL: read_reg = d;
            default: read_reg = cirq_pkg::UNMAPPED_READ;
        endcase
    endfunction : read_reg

    assign rd_byte = read_reg(ptr_q, mask_q, summary, detail_q);

    // ==========================================
    // i2c target state machine
    assign wr_en = (st_q == ST_WDATA) && scl_fall && (cnt_q == cirq_pkg::BITS_PER_BYTE)
        && (ptr_q == cirq_pkg::OFS_MASK);

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            nack_q <= 1'b0;
            sda_oe_o <= 1'b0;
            sda_o <= 1'b0;
        end
        else if (start_c)
        begin
            st_q <= ST_ADDR;
            cnt_q <= 4'h0;
            sda_oe_o <= 1'b0;
        end
        else if (stop_c)
        begin
            st_q <= ST_IDLE;
            sda_oe_o <= 1'b0;
        end
        else if (scl_rise)
        begin
            shift_q <= {shift_q[6:0], sda_f};
            cnt_q <= cnt_q + 4'h1;
            if (st_q == ST_RDATA_ACK)
            begin
                nack_q <= sda_f;
            end
        end
        else if (scl_fall)
        begin
            case (st_q)
                ST_ADDR:
                begin
                    if (cnt_q == cirq_pkg::BITS_PER_BYTE)
                    begin
                        if (shift_q[7:1] == cirq_pkg::DEV_ADDR)
                        begin
                            st_q <= ST_ADDR_ACK;
                            sda_oe_o <= 1'b1;
                        end
                        else
                        begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK:
                begin
                    cnt_q <= 4'h0;
                    // bit 0 holds the sampled acknowledge, bit 1 the direction
                    if (shift_q[1])
                    begin
                        tx_q <= rd_byte;
                        sda_oe_o <= ~rd_byte[7];
                        st_q <= ST_RDATA;
                    end
                    else
                    begin
                        sda_oe_o <= 1'b0;
                        st_q <= ST_PTR;
                    end
                end
                ST_PTR:
                begin
                    if (cnt_q == cirq_pkg::BITS_PER_BYTE)
                    begin
                        ptr_q <= shift_q;
                        sda_oe_o <= 1'b1;
                        st_q <= ST_PTR_ACK;
                    end
                end
                ST_WDATA:
                begin
                    if (cnt_q == cirq_pkg::BITS_PER_BYTE)
                    begin
                        ptr_q <= ptr_q + 8'h01;
                        sda_oe_o <= 1'b1;
                        st_q <= ST_WDATA_ACK;
                    end
                end
                ST_PTR_ACK, ST_WDATA_ACK:
                begin
                    cnt_q <= 4'h0;
                    sda_oe_o <= 1'b0;
                    st_q <= ST_WDATA;
                end
                ST_RDATA:
                begin
                    if (cnt_q == cirq_pkg::BITS_PER_BYTE)
                    begin
                        ptr_q <= ptr_q + 8'h01;
                        sda_oe_o <= 1'b0;
                        st_q <= ST_RDATA_ACK;
                    end
                    else
                    begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        sda_oe_o <= ~tx_q[6];
                    end
                end
                ST_RDATA_ACK:
                begin
                    cnt_q <= 4'h0;
                    if (nack_q)
                    begin
                        st_q <= ST_IDLE;
                    end
                    else
                    begin
                        tx_q <= rd_byte;
                        sda_oe_o <= ~rd_byte[7];
                        st_q <= ST_RDATA;
                    end
                end
                default:
                begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // mask register
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mask_q <= cirq_pkg::MASK_RST;
        end
        else if (pg_rise)
        begin
            mask_q <= cirq_pkg::MASK_RST;
        end
        else if (wr_en)
        begin
            mask_q <= shift_q & cirq_pkg::MASK_WR_BITS;
        end
    end

    // ==========================================
    // detail register and state codes
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            detail_q <= cirq_pkg::DETAIL_RST;
            chg_code_q <= cirq_pkg::CHG_CODE_RST;
            bat_code_q <= cirq_pkg::BAT_CODE_RST;
        end
        else if (pg_rise)
        begin
            detail_q <= cirq_pkg::DETAIL_RST;
            chg_code_q <= cirq_pkg::CHG_CODE_RST;
            bat_code_q <= cirq_pkg::BAT_CODE_RST;
        end
        else
        begin
            detail_q <= {syn[12], syn[11], syn[10], syn[9], 1'b0, syn[8:6]};
            chg_code_q <= syn[5:2];
            bat_code_q <= syn[1:0];
        end
    end

    // ==========================================
    // interrupt output
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            charger_irq_o <= 1'b0;
        end
        else
        begin
            charger_irq_o <= |(irq_pending_i & ~mask_q[7:1]);
        end
    end

    // ==========================================
    // assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    property p_mask_reset;
        pg_rise |=> (mask_q == cirq_pkg::MASK_RST);
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("mask not cleared");

    property p_mask_blocks;
        (irq_pending_i == 7'h40) && mask_q[7] && !wr_en && !pg_rise |=> !charger_irq_o;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("masked source irq");

    property p_irq_gate;
        charger_irq_o == |($past(irq_pending_i) & ~$past(mask_q[7:1]));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq mismatch");

    property p_sum_input;
        (summary[7] == detail_q[7]) && (summary[6] == detail_q[6]);
    endproperty
    a_sum_input: assert property (p_sum_input) else $error("input summary");

    property p_sum_ovp;
        summary[5] == detail_q[5];
    endproperty
    a_sum_ovp: assert property (p_sum_ovp) else $error("ovp summary");

    property p_sum_uvp;
        summary[4] != detail_q[4];
    endproperty
    a_sum_uvp: assert property (p_sum_uvp) else $error("uvp summary");

    property p_sum_chg;
        summary[3] == ((chg_code_q >= 4'h5) && (chg_code_q <= 4'h8));
    endproperty
    a_sum_chg: assert property (p_sum_chg) else $error("charger summary");

    property p_sum_bat;
        summary[2] == bat_code_q[0];
    endproperty
    a_sum_bat: assert property (p_sum_bat) else $error("battery summary");

    property p_sum_thm;
        summary[1] == !((detail_q[2:0] == 3'h4) || (detail_q[2:0] == 3'h5));
    endproperty
    a_sum_thm: assert property (p_sum_thm) else $error("thermistor summary");

    property p_detail_follow;
        !pg_rise |=> (detail_q == {$past(syn[12:9]), 1'b0, $past(syn[8:6])});
    endproperty
    a_detail_follow: assert property (p_detail_follow) else $error("detail stale");

    c_mask_write: cover property (wr_en);
    c_read_byte: cover property ((st_q == ST_RDATA_ACK) && scl_fall && !nack_q);
    c_irq: cover property ($rose(charger_irq_o));
    c_pg_reset: cover property (pg_rise && (mask_q != 8'h00));

endmodule : cirq_regs

/* verification/cirq_i2c_host.sv */
// partner model: i2c controller on an open-drain data line with pull-up
`timescale 1ns/100ps
module cirq_i2c_host (
    // clock
    input wire logic clk_sys_i,
    // bus
    input wire logic dev_oe_i,
    output logic scl_o,
    output logic sda_o
);
    // ==========================================
    // line drivers
    logic scl_q = 1'h1;
    logic low_q = 1'h0;

    // pull-up: the line is high unless some party pulls it low
    assign sda_o = ~(low_q | dev_oe_i);
    assign scl_o = scl_q;

    // ==========================================
    // bus conditions, each clock phase of a data bit held for 12 clocks, line changes at least 4 clocks apart
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : tick

    task automatic start();
        tick(4);
        low_q <= 1'h0;
        tick(4);
        scl_q <= 1'h1;
        tick(12);
        low_q <= 1'h1;
        tick(12);
        scl_q <= 1'h0;
    endtask : start

    task automatic stop();
        tick(4);
        low_q <= 1'h1;
        tick(8);
        scl_q <= 1'h1;
        tick(12);
        low_q <= 1'h0;
        tick(12);
    endtask : stop

    // one bit: data set while the clock is low, line read late in the high phase
    task automatic bit_x(input logic b, output logic r);
        tick(4);
        low_q <= ~b;
        tick(8);
        scl_q <= 1'h1;
        tick(10);
        #1;
        r = sda_o;
        tick(2);
        scl_q <= 1'h0;
    endtask : bit_x

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r);
        bit_x(1'h1, r);
        ack = ~r;
    endtask : wbyte

    // last high sends the closing not-acknowledge
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(1'h1, r);
            d[i] = r;
        end
        bit_x(last, r);
    endtask : rbyte

endmodule : cirq_i2c_host

/* verification/cirq_bench.sv */
// testbench: register access over i2c, status decoding and interrupt masking
`timescale 1ns/100ps
module cirq_bench;
    // ==========================================
    // signals
    logic clk_sys_i = 1'h0;
    logic nrst_i = 1'h0;
    logic scl;
    logic sda;
    logic sda_oe;
    logic sda_lvl;
    logic pg = 1'h0;
    logic inv = 1'h0;
    logic lim = 1'h0;
    logic ovp = 1'h0;
    logic uvp = 1'h0;
    logic [2:0] zone = 3'h0;
    logic [3:0] chg = 4'h0;
    logic [1:0] bat = 2'h0;
    logic [6:0] pend = 7'h0;
    logic irq;
    int err_total = 0;
    int compares = 0;

    always #2 clk_sys_i = ~clk_sys_i;

    // ==========================================
    // design and partner
    cirq_regs DUT (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .scl_i(scl),
        .sda_i(sda),
        .sda_o(sda_lvl),
        .sda_oe_o(sda_oe),
        .safe_output_power_good_i(pg),
        .input_voltage_invalid_i(inv),
        .input_current_limited_i(lim),
        .input_overvolt_detail_i(ovp),
        .input_undervolt_detail_i(uvp),
        .thermistor_zone_code_i(zone),
        .charger_state_code_i(chg),
        .battery_state_code_i(bat),
        .irq_pending_i(pend),
        .charger_irq_o(irq)
    );

    cirq_i2c_host HOST (
        .clk_sys_i(clk_sys_i),
        .dev_oe_i(sda_oe),
        .scl_o(scl),
        .sda_o(sda)
    );

    // ==========================================
    // checking and access tasks
    task automatic close_out();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] d);
        logic a;
        HOST.start();
        HOST.wbyte({cirq_pkg::DEV_ADDR, 1'h0}, a);
        chk({7'h0, a}, 8'h01, "address ack on write");
        HOST.wbyte(ofs, a);
        chk({7'h0, a}, 8'h01, "pointer ack");
        HOST.wbyte(d, a);
        chk({7'h0, a}, 8'h01, "data ack");
        HOST.stop();
    endtask : reg_wr

    task automatic rd_pair(input logic [7:0] ofs, output logic [7:0] b0, output logic [7:0] b1);
        logic a;
        HOST.start();
        HOST.wbyte({cirq_pkg::DEV_ADDR, 1'h0}, a);
        chk({7'h0, a}, 8'h01, "address ack before read");
        HOST.wbyte(ofs, a);
        chk({7'h0, a}, 8'h01, "pointer ack before read");
        HOST.start();
        HOST.wbyte({cirq_pkg::DEV_ADDR, 1'h1}, a);
        chk({7'h0, a}, 8'h01, "address ack on read");
        HOST.rbyte(1'h0, b0);
        HOST.rbyte(1'h1, b1);
        HOST.stop();
    endtask : rd_pair

    task automatic irq_is(input logic exp, input string what);
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk({7'h0, irq}, {7'h0, exp}, what);
    endtask : irq_is

    // ==========================================
    // watchdog, well beyond the expected run of some 35600 cycles
    initial
    begin
        repeat (90000) @(posedge clk_sys_i);
        err_total++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        close_out();
    end

    // ==========================================
    // test sequence
    initial
    begin
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] s;
        logic [7:0] d;
        logic a;
        repeat (8) @(posedge clk_sys_i);
        nrst_i <= 1'h1;
        repeat (10) @(posedge clk_sys_i);
        #1;
        chk({7'h0, irq}, 8'h00, "irq after reset");

        // reset values, then an unmapped place
        rd_pair(cirq_pkg::OFS_MASK, b0, b1);
        chk(b0, 8'h00, "mask after reset");
        chk(b1, 8'h12, "summary after reset");
        chk({7'h0, sda_lvl}, 8'h00, "open-drain data level");
        rd_pair(cirq_pkg::OFS_DETAIL, b0, b1);
        chk(b0, 8'h00, "detail after reset");
        chk(b1, 8'h00, "next place after detail");
        rd_pair(8'h05, b0, b1);
        chk(b0, 8'h00, "unmapped read");

        // wrong device address is not acknowledged
        HOST.start();
        HOST.wbyte({cirq_pkg::DEV_ADDR ^ 7'h01, 1'h0}, a);
        chk({7'h0, a}, 8'h00, "foreign address ack");
        HOST.stop();

        // mask read/write, bit 0 unused, read-only detail ignores writes
        reg_wr(cirq_pkg::OFS_MASK, 8'hff);
        rd_pair(cirq_pkg::OFS_MASK, b0, b1);
        chk(b0, 8'hfe, "mask all ones");
        reg_wr(cirq_pkg::OFS_MASK, 8'h55);
        reg_wr(cirq_pkg::OFS_DETAIL, 8'hff);
        rd_pair(cirq_pkg::OFS_MASK, b0, b1);
        chk(b0, 8'h54, "mask pattern");
        rd_pair(cirq_pkg::OFS_DETAIL, b0, b1);
        chk(b0, 8'h00, "detail after write attempt");

        // each mask bit against its own pending flag and the others
        for (int i = 0; i < 7; i++)
        begin
            reg_wr(cirq_pkg::OFS_MASK, 8'(2 << i));
            @(posedge clk_sys_i);
            pend <= 7'(1 << i);
            irq_is(1'h0, "masked source raised irq");
            @(posedge clk_sys_i);
            pend <= 7'h7f ^ 7'(1 << i);
            irq_is(1'h1, "unmasked sources gave no irq");
        end
        @(posedge clk_sys_i);
        pend <= 7'h0;
        irq_is(1'h0, "irq with nothing pending");

        // power-good rise clears the mask
        reg_wr(cirq_pkg::OFS_MASK, 8'hfe);
        @(posedge clk_sys_i);
        pend <= 7'h7f;
        irq_is(1'h0, "fully masked irq");
        @(posedge clk_sys_i);
        pg <= 1'h1;
        repeat (10) @(posedge clk_sys_i);
        pg <= 1'h0;
        irq_is(1'h1, "irq after power-good clear");
        rd_pair(cirq_pkg::OFS_MASK, b0, b1);
        chk(b0, 8'h00, "mask after power-good rise");
        @(posedge clk_sys_i);
        pend <= 7'h0;

        // status decoding over every charger code and all zone and battery codes
        for (int k = 0; k < 16; k++)
        begin
            @(posedge clk_sys_i);
            inv <= k[0];
            lim <= k[1];
            ovp <= k[2];
            uvp <= k[3];
            zone <= 3'(k + 3);
            chg <= 4'(k);
            bat <= 2'(k >> 1);
            repeat (12) @(posedge clk_sys_i);
            d = {inv, lim, ovp, uvp, 1'h0, zone};
            s = {inv, lim, ovp, ~uvp, chg >= 4'h5 && chg <= 4'h8, bat[0],
                zone != 3'h4 && zone != 3'h5, 1'h0};
            rd_pair(cirq_pkg::OFS_SUMMARY, b0, b1);
            chk(b0, s, "summary status");
            chk(b1, d, "detail status");
        end
        close_out();
    end

endmodule : cirq_bench
